// File: eabc_top.sv
// eabc_top: external area bus controller with wishbone register slave.
// assumes masters hold requests until their ack pulse; pins are async.
`timescale 1ns/1ns
`default_nettype none
module eabc_top
  import eabc_pkg::*;
#(
  parameter int AW       = 24,
  parameter int BUS_DIV  = 4,
  parameter int PERI_DIV = 8
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // strap: high for 16-bit boot
  input  wire logic          boot16_i,
  // wishbone register slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // cpu external port
  input  wire logic          cpu_req_i,
  input  wire logic          cpu_we_i,
  input  wire logic [AW-1:0] cpu_addr_i,
  input  wire logic [15:0]   cpu_wdata_i,
  input  wire logic [1:0]    cpu_be_i,
  output logic               cpu_ack_o,
  output logic [15:0]        cpu_rdata_o,
  // dma external port
  input  wire logic          dma_req_i,
  input  wire logic          dma_we_i,
  input  wire logic          dma_single_i,
  input  wire logic [AW-1:0] dma_addr_i,
  input  wire logic [15:0]   dma_wdata_i,
  input  wire logic [1:0]    dma_be_i,
  output logic               dma_ack_o,
  output logic [15:0]        dma_rdata_o,
  // cpu peripheral write port
  input  wire logic          pw_req_i,
  input  wire logic [15:0]   pw_addr_i,
  input  wire logic [15:0]   pw_wdata_i,
  output logic               pw_ack_o,
  output logic               peri_we_o,
  output logic [15:0]        peri_addr_o,
  output logic [15:0]        peri_wdata_o,
  // external bus pins
  output logic [AW-1:0]      ext_addr_o,
  output logic [15:0]        ext_data_o,
  output logic [1:0]         ext_data_oe_o,
  input  wire logic [15:0]   ext_data_i,
  output logic [AREAS-1:0]   ext_cs_n_o,
  output logic               ext_rd_n_o,
  output logic               ext_wr_n_o,
  output logic               ext_dack_o
);
  typedef struct packed {
    eabc_state_type st;
    logic [15:0]    bwc;
    logic [7:0]     ast;
    logic [15:0]    wca;
    logic [15:0]    wcb;
    logic [5:0]     idl;
    logic [7:0]     rdn;
    logic [7:0]     endi;
    logic           strap_s1;
    logic           strap_s2;
    logic [1:0]     strap_cnt;
    logic [15:0]    din_s1;
    logic [15:0]    din_s2;
    logic           wb_ack;
    logic [31:0]    wb_dat;
    logic [7:0]     bdiv;
    logic [7:0]     pdiv;
    logic           dma;
    logic           we;
    logic           w8;
    logic           three;
    logic           early;
    logic           le;
    logic           dsa;
    logic           phase;
    logic [2:0]     wcnt;
    logic [1:0]     icnt;
    logic [AW-1:0]  addr;
    logic [15:0]    wdat;
    logic [1:0]     be;
    logic [15:0]    rdat;
    logic           lv;
    logic           lrd;
    logic           ldsa;
    logic [2:0]     larea;
    logic           cpu_ack;
    logic           dma_ack;
    logic           pw_ack;
  } eabc_regs_type;
  eabc_regs_type r_reg, r_next;

  logic          bus_ce, peri_ce, gnt_cpu, gnt_dma, start, fin, done;
  logic          xw_ready, xw_valid, xw_take, pw_ready, pw_valid;
  logic [AW+17:0] xw_data;
  logic [31:0]   pw_data;
  logic          active, last_st, lane, rda, wb_wr;
  logic [2:0]    area, n_area;
  logic          n_we, n_idle;
  logic [AW-1:0] n_addr;
  logic [15:0]   n_wdat;
  logic [1:0]    n_be;
  logic [31:0]   wait_all;

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  assign bus_ce  = r_reg.bdiv == 8'(BUS_DIV - 1);
  assign peri_ce = r_reg.pdiv == 8'(PERI_DIV - 1);

  // external posted writes from the cpu
  assign xw_valid = cpu_req_i && cpu_we_i && !r_reg.cpu_ack;
  eabc_wr_buffer #(.W(AW + 18)) u_xbuf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (xw_valid),
    .in_ready_o  (xw_ready),
    .in_data_i   ({cpu_addr_i, cpu_wdata_i, cpu_be_i}),
    .out_valid_o (xw_take),
    .out_ready_i (start && gnt_cpu),
    .out_data_o  (xw_data)
  );

  // peripheral writes drained on the peripheral enable
  assign pw_valid = pw_req_i && !r_reg.pw_ack;
  eabc_wr_buffer #(.W(32)) u_pbuf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pw_valid),
    .in_ready_o  (pw_ready),
    .in_data_i   ({pw_addr_i, pw_wdata_i}),
    .out_valid_o (peri_we_o),
    .out_ready_i (peri_ce),
    .out_data_o  (pw_data)
  );
  assign peri_addr_o  = pw_data[31:16];
  assign peri_wdata_o = pw_data[15:0];

  // one master owns the external bus; buffered writes drain before cpu reads
  eabc_arbiter u_arb (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .req_cpu_i (xw_take || (cpu_req_i && !cpu_we_i && !r_reg.cpu_ack)),
    .req_dma_i (dma_req_i && !r_reg.dma_ack),
    .release_i (done),
    .gnt_cpu_o (gnt_cpu),
    .gnt_dma_o (gnt_dma)
  );

  // request that starts next, and where it lands
  always_comb begin
    if (gnt_dma) begin
      n_we = dma_we_i;
      n_addr = dma_addr_i;
      n_wdat = dma_wdata_i;
      n_be = dma_be_i;
    end else if (xw_take) begin
      n_we = 1'b1;
      n_addr = xw_data[AW+17:18];
      n_wdat = xw_data[17:2];
      n_be = xw_data[1:0];
    end else begin
      n_we = 1'b0;
      n_addr = cpu_addr_i;
      n_wdat = cpu_wdata_i;
      n_be = cpu_be_i;
    end
  end
  // area taken from the top address bits
  assign n_area   = n_addr[AW-1 -: 3];
  assign area     = r_reg.addr[AW-1 -: 3];
  assign wait_all = {r_reg.wca, r_reg.wcb};

  // idle need from the previous access
  assign n_idle = r_reg.lv && (
      (r_reg.idl[IDL_RR] && r_reg.lrd && !n_we && n_area != r_reg.larea) ||
      (r_reg.idl[IDL_RW] && r_reg.lrd && n_we) ||
      (r_reg.idl[IDL_WR] && !r_reg.lrd && !n_we) ||
      (r_reg.idl[IDL_DS] && r_reg.ldsa));

  // cycle phases
  assign start   = bus_ce && r_reg.st == ST_IDLE && (gnt_cpu || gnt_dma);
  assign active  = r_reg.st == ST_T1 || r_reg.st == ST_T2 || r_reg.st == ST_TW || r_reg.st == ST_T3;
  assign last_st = (r_reg.st == ST_T2 && !r_reg.three) || r_reg.st == ST_T3;
  assign fin     = bus_ce && last_st;
  assign done    = fin && !(r_reg.w8 && (&r_reg.be) && !r_reg.phase);
  // early negation lifts the strobe for the last state
  assign rda     = active && !r_reg.we && !(last_st && r_reg.early);
  // byte lane in use; big endian puts the upper byte first
  assign lane    = (&r_reg.be) ? (r_reg.phase ^ !r_reg.le) : r_reg.be[1];
  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.wb_ack;

  // next state of the whole block
  always_comb begin
    r_next = r_reg;
    r_next.cpu_ack = 1'b0;
    r_next.dma_ack = 1'b0;
    r_next.pw_ack = pw_valid && pw_ready;
    r_next.strap_s1 = boot16_i;
    r_next.strap_s2 = r_reg.strap_s1;
    r_next.din_s1 = ext_data_i;
    r_next.din_s2 = r_reg.din_s1;
    r_next.bdiv = bus_ce ? 8'h00 : r_reg.bdiv + 8'h01;
    r_next.pdiv = peri_ce ? 8'h00 : r_reg.pdiv + 8'h01;
    if (xw_valid && xw_ready) r_next.cpu_ack = 1'b1;
    // strap loads area 0 width once synchronised
    if (r_reg.strap_cnt != STRAP_SETTLE) begin
      r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
      if (r_reg.strap_cnt == STRAP_SETTLE - 2'h1)
        r_next.bwc = r_reg.strap_s2 ? RST_BWC_16 : RST_BWC_8;
    end
    // wishbone slave: one wait state, write lands on the ack edge
    r_next.wb_ack = wb_cyc_i && wb_stb_i && !r_reg.wb_ack;
    r_next.wb_dat = 32'h0000_0000;
    if (wb_adr_i == OFS_BWC) r_next.wb_dat[15:0] = r_reg.bwc;
    else if (wb_adr_i == OFS_AST) r_next.wb_dat[15:8] = r_reg.ast;
    else if (wb_adr_i == OFS_WCA) r_next.wb_dat[15:0] = r_reg.wca;
    else if (wb_adr_i == OFS_WCB) r_next.wb_dat[15:0] = r_reg.wcb;
    else if (wb_adr_i == OFS_IDL) r_next.wb_dat[5:0] = r_reg.idl;
    else if (wb_adr_i == OFS_RDN) r_next.wb_dat[7:0] = r_reg.rdn;
    else if (wb_adr_i == OFS_END) r_next.wb_dat[7:0] = r_reg.endi;
    else if (wb_adr_i == OFS_STS)
      r_next.wb_dat[3:0] = {r_reg.st != ST_IDLE, xw_take, peri_we_o, r_reg.dma};
    if (wb_wr) begin
      // lower width bits are held at one
      if (wb_adr_i == OFS_BWC)
        r_next.bwc = merge16(r_reg.bwc, wb_dat_i[15:0], wb_sel_i[1:0]) | LOWER_FORCE;
      else if (wb_adr_i == OFS_AST && wb_sel_i[1]) r_next.ast = wb_dat_i[15:8];
      else if (wb_adr_i == OFS_WCA)
        r_next.wca = merge16(r_reg.wca, wb_dat_i[15:0], wb_sel_i[1:0]) & WC_MASK;
      else if (wb_adr_i == OFS_WCB)
        r_next.wcb = merge16(r_reg.wcb, wb_dat_i[15:0], wb_sel_i[1:0]) & WC_MASK;
      else if (wb_adr_i == OFS_IDL && wb_sel_i[0]) r_next.idl = wb_dat_i[5:0];
      else if (wb_adr_i == OFS_RDN && wb_sel_i[0]) r_next.rdn = wb_dat_i[7:0];
      else if (wb_adr_i == OFS_END && wb_sel_i[0]) r_next.endi = wb_dat_i[7:0];
    end
    // read capture: last synchronised sample while the strobe is low
    if (bus_ce && rda) begin
      if (!r_reg.w8) r_next.rdat = r_reg.le ? {r_reg.din_s2[7:0], r_reg.din_s2[15:8]}
                                            : r_reg.din_s2;
      else if (lane) r_next.rdat[15:8] = r_reg.din_s2[7:0];
      else r_next.rdat[7:0] = r_reg.din_s2[7:0];
    end
    // external access sequencer, advanced on the bus enable only
    if (bus_ce) begin
      case (r_reg.st)
        ST_IDLE: begin
          if (start) begin
            r_next.dma = gnt_dma;
            r_next.we = n_we;
            r_next.addr = n_addr;
            r_next.wdat = n_wdat;
            r_next.be = n_be;
            r_next.dsa = gnt_dma && dma_single_i;
            r_next.phase = 1'b0;
            r_next.w8 = r_reg.bwc[BWC_UPPER + n_area] && r_reg.bwc[n_area];
            // access-state bit picks 3-state with waits
            r_next.three = r_reg.ast[n_area];
            r_next.wcnt = wait_all[n_area * WC_STRIDE +: 3];
            r_next.early = r_reg.rdn[n_area];
            r_next.le = r_reg.endi[n_area];
            r_next.icnt = r_reg.idl[IDL_CNT +: 2];
            r_next.st = n_idle ? ST_IDLEC : ST_T1;
          end
        end
        ST_IDLEC: begin
          if (r_reg.icnt == 2'h0) r_next.st = ST_T1;
          else r_next.icnt = r_reg.icnt - 2'h1;
        end
        ST_T1: r_next.st = ST_T2;
        ST_T2: begin
          if (r_reg.three) r_next.st = (r_reg.wcnt != 3'h0) ? ST_TW : ST_T3;
        end
        ST_TW: begin
          r_next.wcnt = r_reg.wcnt - 3'h1;
          if (r_reg.wcnt == 3'h1) r_next.st = ST_T3;
        end
        default: ;
      endcase
      if (fin) begin
        if (done) begin
          r_next.st = ST_IDLE;
          r_next.lv = 1'b1;
          r_next.lrd = !r_reg.we;
          r_next.ldsa = r_reg.dsa && r_reg.we;
          r_next.larea = area;
          r_next.dma_ack = r_reg.dma;
          if (!r_reg.dma && !r_reg.we) r_next.cpu_ack = 1'b1;
        end else begin
          r_next.phase = 1'b1;
          r_next.st = ST_T1;
          r_next.wcnt = wait_all[area * WC_STRIDE +: 3];
        end
      end
    end
    // synchronous reset to constants only
    if (rst_i) begin
      r_next = '0;
      r_next.bwc = RST_BWC_8;
      r_next.ast = RST_AST;
      r_next.wca = RST_WC;
      r_next.wcb = RST_WC;
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  // outputs
  assign wb_ack_o    = r_reg.wb_ack;
  assign wb_dat_o    = r_reg.wb_dat;
  assign cpu_ack_o   = r_reg.cpu_ack;
  assign dma_ack_o   = r_reg.dma_ack;
  assign pw_ack_o    = r_reg.pw_ack;
  assign cpu_rdata_o = r_reg.rdat;
  assign dma_rdata_o = r_reg.rdat;
  assign ext_addr_o  = {r_reg.addr[AW-1:1], r_reg.w8 && (r_reg.le ? lane : !lane)};
  // byte swap on 16-bit little-endian areas
  assign ext_data_o  = r_reg.w8 ? {8'h00, lane ? r_reg.wdat[15:8] : r_reg.wdat[7:0]}
                     : (r_reg.le ? {r_reg.wdat[7:0], r_reg.wdat[15:8]} : r_reg.wdat);
  // single-address dma leaves the data bus to the device pair
  assign ext_data_oe_o = (active && r_reg.we && !r_reg.dsa) ? {!r_reg.w8, 1'b1} : 2'b00;
  assign ext_cs_n_o  = active ? ~(8'h01 << area) : 8'hFF;
  assign ext_rd_n_o  = !rda;
  assign ext_wr_n_o  = !(active && r_reg.we && r_reg.st != ST_T1);
  assign ext_dack_o  = active && r_reg.dsa;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ONE_OWNER: assert property (!(gnt_cpu && gnt_dma))
    else $error("both masters granted");
  AST_LOWER_ONES: assert property (r_reg.bwc[7:0] == 8'hFF)
    else $error("lower width bit cleared");
  AST_STRAP: assert property (r_reg.strap_cnt == 2'h2 |=>
    r_reg.bwc == ($past(r_reg.strap_s2) ? 16'hFEFF : 16'hFFFF))
    else $error("width reset value wrong");
  AST_TWO_STATE: assert property (bus_ce && r_reg.st == ST_T2 && !r_reg.three
    |=> r_reg.st == ST_IDLE || r_reg.st == ST_T1) else $error("2-state ran long");
  AST_WAIT_ENTRY: assert property (bus_ce && r_reg.st == ST_T2 && r_reg.three
    && r_reg.wcnt == 3'h0 |=> r_reg.st == ST_T3) else $error("wait skipped wrong");
  AST_WAIT_EXIT: assert property (bus_ce && r_reg.st == ST_TW && r_reg.wcnt == 3'h1
    |=> r_reg.st == ST_T3 && r_reg.wcnt == 3'h0) else $error("wait count off");
  AST_W8_LANE: assert property (active && r_reg.w8 |-> !ext_data_oe_o[1])
    else $error("upper lane driven on 8-bit area");
  AST_WIDTH_HOLD: assert property (active && $past(active) && !$past(start)
    |-> $stable(r_reg.w8)) else $error("width changed mid access");
  AST_IDLE_GAP: assert property (r_reg.st == ST_IDLEC |-> ext_cs_n_o == 8'hFF
    && ext_rd_n_o && ext_wr_n_o) else $error("bus active in idle cycle");
  AST_EARLY_RD: assert property (last_st && r_reg.early && !r_reg.we
    |-> ext_rd_n_o) else $error("read strobe not negated early");
  AST_POSTED: assert property (xw_valid && xw_ready |=> cpu_ack_o)
    else $error("posted write not acked");
  AST_PERI_DRAIN: assert property (peri_we_o && peri_ce |=> !peri_we_o)
    else $error("peripheral write not drained");
  AST_DSA_FLOAT: assert property (ext_dack_o |-> ext_data_oe_o == 2'b00)
    else $error("data driven in single-address dma");
  COV_W8_PAIR: cover property (done && r_reg.w8 && r_reg.phase);
  COV_WAITS: cover property (r_reg.st == ST_TW ##1 r_reg.st == ST_T3);
  COV_IDLE: cover property (r_reg.st == ST_IDLEC);
  COV_DMA: cover property (dma_ack_o);
endmodule : eabc_top
`default_nettype wire

// File: eabc_pkg.sv
// eabc_pkg: shared constants of the external area bus controller.
// assumes a 16-bit register file reached over a 32-bit wishbone bus.
`default_nettype none
package eabc_pkg;
  // area count and wishbone byte offsets
  localparam int         AREAS   = 8;
  localparam logic [7:0] OFS_BWC = 8'h00;
  localparam logic [7:0] OFS_AST = 8'h04;
  localparam logic [7:0] OFS_WCA = 8'h08;
  localparam logic [7:0] OFS_WCB = 8'h0C;
  localparam logic [7:0] OFS_IDL = 8'h10;
  localparam logic [7:0] OFS_RDN = 8'h14;
  localparam logic [7:0] OFS_END = 8'h18;
  localparam logic [7:0] OFS_STS = 8'h1C;
  // reset values and fixed bits
  localparam logic [15:0] RST_BWC_8   = 16'hFFFF;
  localparam logic [15:0] RST_BWC_16  = 16'hFEFF;
  localparam logic [15:0] LOWER_FORCE = 16'h00FF;
  localparam logic [7:0]  RST_AST     = 8'hFF;
  localparam logic [15:0] RST_WC      = 16'h7777;
  localparam logic [15:0] WC_MASK     = 16'h7777;
  localparam int          WC_STRIDE   = 4;
  localparam int          BWC_UPPER   = 8;
  // idle control field positions
  localparam int IDL_RR  = 0;
  localparam int IDL_RW  = 1;
  localparam int IDL_WR  = 2;
  localparam int IDL_DS  = 3;
  localparam int IDL_CNT = 4;
  // strap settle: two sync stages plus one load cycle
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // external access states
  typedef enum logic [2:0] {ST_IDLE, ST_IDLEC, ST_T1, ST_T2, ST_TW, ST_T3} eabc_state_type;
endpackage : eabc_pkg
`default_nettype wire

// File: eabc_wr_buffer.sv
// eabc_wr_buffer: one-entry posted write buffer.
// assumes the filler holds in_valid until it sees in_ready.
`timescale 1ns/1ns
`default_nettype none
module eabc_wr_buffer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  typedef struct packed {
    logic         full;
    logic [W-1:0] data;
  } eabc_wb_state_type;
  eabc_wb_state_type r_reg, r_next;

  // a drained entry frees the slot only next cycle, trading speed for a short path
  always_comb begin
    r_next = r_reg;
    if (rst_i) begin
      r_next = '0;
    end else if (r_reg.full) begin
      if (out_ready_i) r_next.full = 1'b0;
    end else if (in_valid_i) begin
      r_next.full = 1'b1;
      r_next.data = in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  assign in_ready_o  = !r_reg.full;
  assign out_valid_o = r_reg.full;
  assign out_data_o  = r_reg.data;
endmodule : eabc_wr_buffer
`default_nettype wire

// File: eabc_arbiter.sv
// eabc_arbiter: grants the external bus to cpu or dma, one at a time.
// assumes release_i pulses in the cycle the owner's access ends.
`timescale 1ns/1ns
`default_nettype none
module eabc_arbiter (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // requests and release
  input  wire logic req_cpu_i,
  input  wire logic req_dma_i,
  input  wire logic release_i,
  // grants
  output logic      gnt_cpu_o,
  output logic      gnt_dma_o
);
  typedef struct packed {
    logic busy;
    logic dma;
  } eabc_arb_state_type;
  eabc_arb_state_type r_reg, r_next;

  // dma wins ties; ownership holds until release
  always_comb begin
    r_next = r_reg;
    if (rst_i || release_i) begin
      r_next = '0;
    end else if (!r_reg.busy && (req_cpu_i || req_dma_i)) begin
      r_next.busy = 1'b1;
      r_next.dma  = req_dma_i;
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  assign gnt_cpu_o = r_reg.busy && !r_reg.dma;
  assign gnt_dma_o = r_reg.busy && r_reg.dma;
endmodule : eabc_arbiter
`default_nettype wire

// File: eabc_sram_model.sv
// eabc_sram_model: behavioural static memory on the external area bus.
// assumes active-low strobes, one word kept per byte address.
`timescale 1ns/1ns
`default_nettype none
module eabc_sram_model (
  // bus pins
  input  wire logic        clk_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic [1:0]  oe_i,
  input  wire logic [7:0]  cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  output logic [15:0]      data_o
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic        rd_on;
  // store only the lanes the controller drives, so a lane slip shows up
  always @(posedge clk_i) begin
    if (!wr_n_i && cs_n_i != 8'hFF && oe_i[0]) mem[addr_i[7:0]][7:0] <= data_i[7:0];
    if (!wr_n_i && cs_n_i != 8'hFF && oe_i[1]) mem[addr_i[7:0]][15:8] <= data_i[15:8];
    if (rd_on) last <= mem[addr_i[7:0]];
  end
  // released bus shows the inverse of the last value, never a stale copy
  assign rd_on  = !rd_n_i && cs_n_i != 8'hFF;
  assign data_o = rd_on ? mem[addr_i[7:0]] : ~last;
endmodule : eabc_sram_model
`default_nettype wire

// File: tb_external_area_bus_controller.sv
// tb_external_area_bus_controller: self-checking bench for eabc_top.
// assumes the static memory model answers on the external pins.
`timescale 1ns/1ns
`default_nettype none
module tb_external_area_bus_controller;
  import eabc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, boot16_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00, ext_cs_n_o;
  logic [3:0]  wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        cpu_req_i = 1'b0, cpu_we_i = 1'b0, dma_req_i = 1'b0, dma_we_i = 1'b0;
  logic        dma_single_i = 1'b0, pw_req_i = 1'b0, cpu_ack_o, dma_ack_o, pw_ack_o;
  logic [23:0] cpu_addr_i = 24'h0, dma_addr_i = 24'h0, ext_addr_o;
  logic [15:0] cpu_wdata_i = 16'h0, dma_wdata_i = 16'h0, cpu_rdata_o, dma_rdata_o;
  logic [15:0] pw_addr_i = 16'h0, pw_wdata_i = 16'h0, peri_addr_o, peri_wdata_o;
  logic [15:0] ext_data_o, ext_data_i;
  logic [1:0]  cpu_be_i = 2'h3, dma_be_i = 2'h3, ext_data_oe_o;
  logic        ext_rd_n_o, ext_wr_n_o, ext_dack_o, peri_we_o;
  int          err_count = 0, checks = 0;
  eabc_top #(.AW(24), .BUS_DIV(4), .PERI_DIV(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .boot16_i(boot16_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req_i(cpu_req_i),
    .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
    .cpu_be_i(cpu_be_i), .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o),
    .dma_req_i(dma_req_i), .dma_we_i(dma_we_i), .dma_single_i(dma_single_i),
    .dma_addr_i(dma_addr_i), .dma_wdata_i(dma_wdata_i), .dma_be_i(dma_be_i),
    .dma_ack_o(dma_ack_o), .dma_rdata_o(dma_rdata_o), .pw_req_i(pw_req_i),
    .pw_addr_i(pw_addr_i), .pw_wdata_i(pw_wdata_i), .pw_ack_o(pw_ack_o),
    .peri_we_o(peri_we_o), .peri_addr_o(peri_addr_o), .peri_wdata_o(peri_wdata_o),
    .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o),
    .ext_data_i(ext_data_i), .ext_cs_n_o(ext_cs_n_o), .ext_rd_n_o(ext_rd_n_o),
    .ext_wr_n_o(ext_wr_n_o), .ext_dack_o(ext_dack_o));
  eabc_sram_model u_mem (
    .clk_i(clk_i), .addr_i(ext_addr_o), .data_i(ext_data_o), .oe_i(ext_data_oe_o),
    .cs_n_i(ext_cs_n_o), .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .data_o(ext_data_i));
  // 125 MHz system clock
  always #4 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // strap held across release so it is sampled settled
  task automatic do_reset(input logic b16);
    boot16_i <= b16;
    rst_i    <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i    <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : do_reset
  // classic wishbone single cycle, request held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : wb
  // external access from cpu or dma port; waits are long with 7 program waits
  task automatic ext(input logic dm, input logic we, input logic [23:0] a,
                     input logic [15:0] d);
    int n = 0;
    @(posedge clk_i);
    {cpu_we_i, cpu_addr_i, cpu_wdata_i} <= {we, a, d};
    {dma_we_i, dma_addr_i, dma_wdata_i} <= {we, a, d};
    {cpu_req_i, dma_req_i} <= {!dm, dm};
    do begin
      @(posedge clk_i);
      n++;
    end while ((dm ? dma_ack_o : cpu_ack_o) !== 1'b1 && n < 600);
    if (n >= 600) err_count++;
    rd = {16'h0, dm ? dma_rdata_o : cpu_rdata_o};
    {cpu_req_i, dma_req_i} <= 2'b00;
  endtask : ext
  task automatic t_regs(input logic [15:0] exp_bwc);
    wb(1'b0, OFS_BWC, 16'h0);
    chk("width reset", {16'h0, exp_bwc}, rd);
    wb(1'b0, OFS_AST, 16'h0);
    chk("access reset", 32'h0000FF00, rd);
    wb(1'b0, OFS_WCA, 16'h0);
    chk("wait reset", 32'h00007777, rd);
    wb(1'b0, 8'h20, 16'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : t_regs
  // lower width bits cannot be cleared; all areas go 16-bit
  task automatic t_width;
    wb(1'b1, OFS_BWC, 16'h00F0);
    wb(1'b0, OFS_BWC, 16'h0);
    chk("width write", 32'h000000FF, rd);
  endtask : t_width
  // 16-bit area 1 and 8-bit area 2, dma reading back the cpu data
  task automatic t_ext;
    ext(1'b0, 1'b1, 24'h200010, 16'hA55A);
    ext(1'b0, 1'b0, 24'h200010, 16'h0);
    chk("area1 16-bit", 32'h0000A55A, rd);
    wb(1'b1, OFS_BWC, 16'h04FF);
    ext(1'b0, 1'b1, 24'h400020, 16'h1234);
    ext(1'b1, 1'b0, 24'h400020, 16'h0);
    chk("area2 8-bit dma", 32'h00001234, rd);
    // only the low lane is driven on an 8-bit area, the upper byte stays unwritten
    chk("area2 8-bit pins", 32'h00000012, {24'h0, u_mem.mem[8'h20][7:0]});
    chk("area2 odd byte", 32'h00000034, {24'h0, u_mem.mem[8'h21][7:0]});
  endtask : t_ext
  // 2-state area 1 with early negation, byte swap, write-to-read idle, single dma
  task automatic t_modes;
    wb(1'b1, OFS_AST, 16'hFD00);
    wb(1'b1, OFS_RDN, 16'h0002);
    wb(1'b1, OFS_END, 16'h0002);
    wb(1'b1, OFS_IDL, 16'h0014);
    ext(1'b0, 1'b1, 24'h200030, 16'hBEEF);
    ext(1'b0, 1'b0, 24'h200030, 16'h0);
    chk("le round trip", 32'h0000BEEF, rd);
    chk("le pins", 32'h0000EFBE, {16'h0, u_mem.mem[8'h30]});
    dma_single_i <= 1'b1;
    ext(1'b1, 1'b1, 24'h200030, 16'h5555);
    dma_single_i <= 1'b0;
    // single-address transfer leaves the data lanes to the device pair
    chk("single dma float", 32'h0000EFBE, {16'h0, u_mem.mem[8'h30]});
  endtask : t_modes
  // posted peripheral write drains with its address and data
  task automatic t_peri;
    int n = 0;
    @(posedge clk_i);
    {pw_req_i, pw_addr_i, pw_wdata_i} <= {1'b1, 16'h0042, 16'hC3C3};
    do begin
      @(posedge clk_i);
      n++;
    end while (pw_ack_o !== 1'b1 && n < 50);
    pw_req_i <= 1'b0;
    n = 0;
    while (peri_we_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("peri write", 32'h0042C3C3, {peri_addr_o, peri_wdata_o});
  endtask : t_peri
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // watchdog sized well above the longest sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end
  initial begin
    do_reset(1'b1);
    t_regs(16'hFEFF);
    t_width();
    t_ext();
    t_modes();
    t_peri();
    do_reset(1'b0);
    t_regs(16'hFFFF);
    final_report();
  end
endmodule : tb_external_area_bus_controller
`default_nettype wire
